// file: sas_regs.v
// Spectral alarm register bank for six sensor nodes behind an AXI4-Lite slave,
// with the per-record alarm evaluation that fills the read-only results.
// Assumes FFT bins arrive already tagged with their band number (0 = no band)
// and that one record of one node streams between rec_start and rec_end.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
`include "sas_map.vh"

module sas_regs #(
   parameter NODES = 6                     // Sensor nodes, one page each
) (
   input  wire        clk,                 // 200 MHz clock
   input  wire        srst,                // Synchronous reset, active high
   input  wire [11:0] s_axi_awaddr,        // Write address
   input  wire        s_axi_awvalid,       // Write address valid
   output wire        s_axi_awready,       // Write address ready
   input  wire [31:0] s_axi_wdata,         // Write data
   input  wire [3:0]  s_axi_wstrb,         // Write byte strobes
   input  wire        s_axi_wvalid,        // Write data valid
   output wire        s_axi_wready,        // Write data ready
   output reg  [1:0]  s_axi_bresp,         // Write response
   output reg         s_axi_bvalid,        // Write response valid
   input  wire        s_axi_bready,        // Write response ready
   input  wire [11:0] s_axi_araddr,        // Read address
   input  wire        s_axi_arvalid,       // Read address valid
   output wire        s_axi_arready,       // Read address ready
   output reg  [31:0] s_axi_rdata,         // Read data
   output reg  [1:0]  s_axi_rresp,         // Read response
   output reg         s_axi_rvalid,        // Read data valid
   input  wire        s_axi_rready,        // Read data ready
   input  wire        rec_start,           // Record begins, pulse
   input  wire        rec_end,             // Record done, pulse
   input  wire [2:0]  rec_node,            // Node page of the record, 1..6
   input  wire [1:0]  rec_rate,            // Sample rate option of the record
   input  wire [15:0] rec_temp,            // Node temperature for the record
   input  wire [15:0] rec_supply,          // Node supply for the record
   input  wire        bin_valid,           // FFT bin valid
   input  wire [7:0]  bin_index,           // FFT bin number
   input  wire [2:0]  bin_band,            // Band of the bin, 0 = none
   input  wire [15:0] bin_x_mag,           // X magnitude of the bin
   input  wire [15:0] bin_y_mag,           // Y magnitude of the bin
   output reg         hdr_valid,           // Record header ready, pulse
   output reg  [2:0]  hdr_node,            // Header node page
   output reg  [15:0] hdr_diag,            // Header diagnostic flags
   output reg  [15:0] hdr_x_stat,          // Header x band status
   output reg  [15:0] hdr_y_stat,          // Header y band status
   output reg  [15:0] hdr_x_peak,          // Header x worst peak
   output reg  [15:0] hdr_y_peak,          // Header y worst peak
   output reg  [7:0]  hdr_x_bin,           // Header x worst bin
   output reg  [7:0]  hdr_y_bin,           // Header y worst bin
   output reg         nv_clear,            // Clear stored alarm definitions, pulse
   output reg         nv_save,             // Save alarm definitions, pulse
   output reg  [2:0]  nv_node,             // Node page of clear or save
   output reg  [5:0]  digital_out_first,   // Warning indicator per node
   output reg  [5:0]  digital_out_second   // Critical indicator per node
);

   // ==========================================================
   // Storage
   reg [15:0] x_warn     [0:NODES-1];
   reg [15:0] y_warn     [0:NODES-1];
   reg [15:0] x_crit     [0:NODES-1];
   reg [15:0] y_crit     [0:NODES-1];
   reg [15:0] sys_lvl    [0:NODES-1];
   reg [15:0] alarm_ctrl [0:NODES-1];
   reg [5:0]  out_ctrl   [0:NODES-1];
   reg [15:0] x_stat     [0:NODES-1];
   reg [15:0] y_stat     [0:NODES-1];
   reg [15:0] x_peak     [0:NODES-1];
   reg [15:0] y_peak     [0:NODES-1];
   reg [7:0]  x_bin      [0:NODES-1];
   reg [7:0]  y_bin      [0:NODES-1];
   reg [1:0]  last_rate  [0:NODES-1];
   reg [4:0]  persist    [0:NODES*24-1];  // node*24 + axis*12 + level*6 + band
   reg [NODES-1:0] sys_flag;
   reg [NODES-1:0] saved;

   // ==========================================================
   // Bus slave
   reg         aw_held;
   reg         w_held;
   reg  [11:0] aw_addr;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;
   wire [2:0]  wpage = aw_addr[11:`SAS_PAGE_LSB];
   wire [6:0]  widx  = aw_addr[8:2];
   wire        wpage_ok = (wpage >= `SAS_PAGE_FIRST) && (wpage <= `SAS_PAGE_LAST);
   wire [2:0]  wn = wpage - 3'h1;
   wire        do_write = aw_held && w_held && !s_axi_bvalid;
   wire [15:0] wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
   wire [15:0] wword = w_data[15:0];
   wire [2:0]  rpage = s_axi_araddr[11:`SAS_PAGE_LSB];
   wire [6:0]  ridx  = s_axi_araddr[8:2];
   wire        rpage_ok = (rpage >= `SAS_PAGE_FIRST) && (rpage <= `SAS_PAGE_LAST);
   wire [2:0]  rn = rpage - 3'h1;
   reg  [15:0] rword;
   reg         rhit;

   assign s_axi_awready = !aw_held;
   assign s_axi_wready  = !w_held;
   assign s_axi_arready = !s_axi_rvalid;

   function [15:0] merge;
      input [15:0] old;
      input [15:0] nw;
      input [15:0] m;
      begin
         merge = (old & ~m) | (nw & m);
      end
   endfunction

   always @(posedge clk) begin
      if (srst) begin
         {aw_held, w_held, s_axi_bvalid} <= 3'h0;
         {aw_addr, w_data, w_strb}       <= 48'h0000_0000_0000;
         s_axi_bresp                     <= `SAS_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wpage_ok ? `SAS_RESP_OKAY : `SAS_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
         end
      end
   end

   // Read mux; result registers answer for their own page only
   always @* begin
      rword = `SAS_ZERO16;
      rhit  = rpage_ok;
      if (rpage_ok) begin
         case (ridx)
            `SAS_IDX_X_WARN:   rword = x_warn[rn];
            `SAS_IDX_Y_WARN:   rword = y_warn[rn];
            `SAS_IDX_X_CRIT:   rword = x_crit[rn];
            `SAS_IDX_Y_CRIT:   rword = y_crit[rn];
            `SAS_IDX_SYS_LVL:  rword = sys_lvl[rn];
            `SAS_IDX_CTRL:     rword = alarm_ctrl[rn];
            `SAS_IDX_DIAG:     rword = {13'h0000, |x_stat[rn][15:4] | |y_stat[rn][15:4],
                                        1'b0, sys_flag[rn]};
            `SAS_IDX_X_STAT:   rword = x_stat[rn];
            `SAS_IDX_Y_STAT:   rword = y_stat[rn];
            `SAS_IDX_X_PEAK:   rword = x_peak[rn];
            `SAS_IDX_Y_PEAK:   rword = y_peak[rn];
            `SAS_IDX_X_BIN:    rword = {8'h00, x_bin[rn]};
            `SAS_IDX_Y_BIN:    rword = {8'h00, y_bin[rn]};
            `SAS_IDX_OUT_CTRL: rword = {10'h000, out_ctrl[rn]};
            default:           rword = `SAS_ZERO16;
         endcase
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `SAS_RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {16'h0000, rword};
         s_axi_rresp  <= rhit ? `SAS_RESP_OKAY : `SAS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Software-written registers and commands
   integer i;
   integer j;
   integer m;

   always @(posedge clk) begin
      if (srst) begin
         for (i = 0; i < NODES; i = i + 1) begin
            {x_warn[i], y_warn[i], x_crit[i], y_crit[i]} <= 64'h0000_0000_0000_0000;
            sys_lvl[i]    <= `SAS_ZERO16;
            alarm_ctrl[i] <= `SAS_CTRL_RESET;
            out_ctrl[i]   <= 6'h00;
         end
         saved                        <= {NODES{1'b0}};
         {nv_clear, nv_save, nv_node} <= 5'h00;
      end else begin
         nv_clear <= 1'b0;
         nv_save  <= 1'b0;
         // Status, peak and bin indices fall to default: writes ignored
         if (do_write && wpage_ok) begin
            case (widx)
               `SAS_IDX_X_WARN:  x_warn[wn]  <= merge(x_warn[wn], wword, wmask);
               `SAS_IDX_Y_WARN:  y_warn[wn]  <= merge(y_warn[wn], wword, wmask);
               `SAS_IDX_X_CRIT:  x_crit[wn]  <= merge(x_crit[wn], wword, wmask);
               `SAS_IDX_Y_CRIT:  y_crit[wn]  <= merge(y_crit[wn], wword, wmask);
               `SAS_IDX_SYS_LVL: sys_lvl[wn] <= merge(sys_lvl[wn], wword, wmask);
               `SAS_IDX_CTRL:    alarm_ctrl[wn] <= merge(alarm_ctrl[wn], wword, wmask);
               `SAS_IDX_OUT_CTRL:
                  if (w_strb[0]) begin
                     out_ctrl[wn] <= wword[5:0];
                  end
               `SAS_IDX_GCMD: begin
                  nv_node <= wpage;
                  // Clear takes priority when both bits are set together
                  if (w_strb[1] && wword[`SAS_GCMD_CLEAR]) begin
                     x_warn[wn] <= `SAS_ZERO16;
                     y_warn[wn] <= `SAS_ZERO16;
                     x_crit[wn] <= `SAS_ZERO16;
                     y_crit[wn] <= `SAS_ZERO16;
                     saved[wn]  <= 1'b0;
                     nv_clear   <= 1'b1;
                  end else if (w_strb[1] && wword[`SAS_GCMD_SAVE]) begin
                     if (!saved[wn]) begin
                        saved[wn] <= 1'b1;
                        nv_save   <= 1'b1;
                     end
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // ==========================================================
   // Per-record accumulation of band hits and worst case
   reg [5:0]  hx_w, hx_c, hy_w, hy_c;
   reg        px_any, px_crit, py_any, py_crit;
   reg [15:0] px_mag, py_mag;
   reg [7:0]  px_bin, py_bin;
   reg [2:0]  px_band, py_band;
   wire       bin_node_ok = (rec_node >= `SAS_PAGE_FIRST) && (rec_node <= `SAS_PAGE_LAST);
   wire [2:0] bn = bin_node_ok ? rec_node - 3'h1 : 3'h0;
   wire       in_band = bin_valid && bin_node_ok && (bin_band != 3'h0) && (bin_band <= 3'h6);
   wire [2:0] bb = bin_band - 3'h1;
   wire       x_on = in_band && alarm_ctrl[bn][`SAS_CTRL_X_EN];
   wire       y_on = in_band && alarm_ctrl[bn][`SAS_CTRL_Y_EN];
   wire       x_w = x_on && (bin_x_mag > x_warn[bn]);
   wire       x_c = x_on && (bin_x_mag > x_crit[bn]);
   wire       y_w = y_on && (bin_y_mag > y_warn[bn]);
   wire       y_c = y_on && (bin_y_mag > y_crit[bn]);

   // A critical hit outranks any warning hit, then larger magnitude wins
   function worse;
      input        crit_new;
      input [15:0] mag_new;
      input        any_old;
      input        crit_old;
      input [15:0] mag_old;
      begin
         worse = !any_old || (crit_new && !crit_old) ||
                 ((crit_new == crit_old) && (mag_new > mag_old));
      end
   endfunction

   always @(posedge clk) begin
      if (srst || rec_start || rec_end) begin
         {hx_w, hx_c, hy_w, hy_c}                   <= 24'h00_0000;
         {px_any, px_crit, px_mag, px_bin, px_band} <= 29'h0000_0000;
         {py_any, py_crit, py_mag, py_bin, py_band} <= 29'h0000_0000;
      end else begin
         if (x_w) begin
            hx_w[bb] <= 1'b1;
            hx_c[bb] <= hx_c[bb] | x_c;
            if (worse(x_c, bin_x_mag, px_any, px_crit, px_mag)) begin
               px_any  <= 1'b1;
               px_crit <= x_c;
               px_mag  <= bin_x_mag;
               px_bin  <= bin_index;
               px_band <= bin_band;
            end
         end
         if (y_w) begin
            hy_w[bb] <= 1'b1;
            hy_c[bb] <= hy_c[bb] | y_c;
            if (worse(y_c, bin_y_mag, py_any, py_crit, py_mag)) begin
               py_any  <= 1'b1;
               py_crit <= y_c;
               py_mag  <= bin_y_mag;
               py_bin  <= bin_index;
               py_band <= bin_band;
            end
         end
      end
   end

   // ==========================================================
   // End of record: persistence, status, system alarm, header
   wire [2:0]  en = bn;
   wire        rec_ok = rec_end && bin_node_ok;
   wire        rate_same = (rec_rate == last_rate[en]);
   wire [3:0]  delay = alarm_ctrl[en][`SAS_CTRL_DLY_LSB+3:`SAS_CTRL_DLY_LSB];
   wire [23:0] hits = {hy_c, hy_w, hx_c, hx_w};
   wire [15:0] sys_val = alarm_ctrl[en][`SAS_CTRL_SYS_TEMP] ? rec_temp : rec_supply;
   wire        sys_trip = alarm_ctrl[en][`SAS_CTRL_SYS_EN] &&
                          (alarm_ctrl[en][`SAS_CTRL_SYS_BELOW] ? (sys_val < sys_lvl[en])
                                                               : (sys_val > sys_lvl[en]));
   reg  [4:0]  next_cnt [0:23];
   reg  [23:0] flag;
   reg  [15:0] next_x_stat, next_y_stat;
   integer     k;

   always @* begin
      for (k = 0; k < 24; k = k + 1) begin
         // Counting restarts when the record's rate option changes
         if (!hits[k]) begin
            next_cnt[k] = 5'h00;
         end else if (!rate_same) begin
            next_cnt[k] = 5'h01;
         end else if (persist[en*24+k] == 5'h10) begin
            next_cnt[k] = 5'h10;
         end else begin
            next_cnt[k] = persist[en*24+k] + 5'h01;
         end
         flag[k] = next_cnt[k] > {1'b0, delay};
      end
      next_x_stat = {12'h000, 1'b0, (px_any ? px_band : 3'h0)};
      next_y_stat = {12'h000, 1'b0, (py_any ? py_band : 3'h0)};
      for (k = 0; k < 6; k = k + 1) begin
         next_x_stat[2*k+4] = flag[k];
         next_x_stat[2*k+5] = flag[6+k];
         next_y_stat[2*k+4] = flag[12+k];
         next_y_stat[2*k+5] = flag[18+k];
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         for (j = 0; j < NODES; j = j + 1) begin
            {x_stat[j], y_stat[j], x_peak[j], y_peak[j]} <= 64'h0000_0000_0000_0000;
            {x_bin[j], y_bin[j], last_rate[j]}           <= 18'h0_0000;
         end
         for (j = 0; j < NODES*24; j = j + 1) begin
            persist[j] <= 5'h00;
         end
         sys_flag  <= {NODES{1'b0}};
         hdr_valid <= 1'b0;
         {hdr_node, hdr_diag, hdr_x_stat, hdr_y_stat}   <= 51'h0_0000_0000_0000;
         {hdr_x_peak, hdr_y_peak, hdr_x_bin, hdr_y_bin} <= 48'h0000_0000_0000;
      end else begin
         hdr_valid <= 1'b0;
         if (rec_ok) begin
            for (j = 0; j < 24; j = j + 1) begin
               persist[en*24+j] <= next_cnt[j];
            end
            last_rate[en] <= rec_rate;
            x_stat[en]    <= next_x_stat;
            y_stat[en]    <= next_y_stat;
            x_peak[en]    <= px_any ? px_mag : `SAS_ZERO16;
            y_peak[en]    <= py_any ? py_mag : `SAS_ZERO16;
            x_bin[en]     <= px_any ? px_bin : 8'h00;
            y_bin[en]     <= py_any ? py_bin : 8'h00;
            sys_flag[en]  <= sys_trip;
            hdr_valid     <= 1'b1;
            hdr_node      <= rec_node;
            hdr_diag      <= {13'h0000, |next_x_stat[15:4] | |next_y_stat[15:4],
                              1'b0, sys_trip};
            hdr_x_stat    <= next_x_stat;
            hdr_y_stat    <= next_y_stat;
            hdr_x_peak    <= px_any ? px_mag : `SAS_ZERO16;
            hdr_y_peak    <= py_any ? py_mag : `SAS_ZERO16;
            hdr_x_bin     <= px_any ? px_bin : 8'h00;
            hdr_y_bin     <= py_any ? py_bin : 8'h00;
         end
      end
   end

   // ==========================================================
   // Alarm indicator outputs
   always @(posedge clk) begin
      if (srst) begin
         digital_out_first  <= 6'h00;
         digital_out_second <= 6'h00;
      end else begin
         for (m = 0; m < NODES; m = m + 1) begin
            // Warnings sit at even bits 4..14, criticals at odd bits 5..15
            digital_out_first[m]  <= alarm_ctrl[m][`SAS_CTRL_DO_EN] &&
                                     out_ctrl[m][`SAS_OUT_FIRST_SEL] &&
                                     |((x_stat[m] | y_stat[m]) & 16'h5550);
            digital_out_second[m] <= alarm_ctrl[m][`SAS_CTRL_DO_EN] &&
                                     out_ctrl[m][`SAS_OUT_SECOND_SEL] &&
                                     |((x_stat[m] | y_stat[m]) & 16'haaa0);
         end
      end
   end

endmodule

// file: sas_map.vh
// Constants for the spectral alarm register bank: register indices,
// field positions, reset values and bus answer codes.
// Assumes it is included by the register bank module only.
`ifndef SAS_MAP_VH
`define SAS_MAP_VH

// Register indices; byte address is page*0x200 + index*4
`define SAS_IDX_X_WARN     7'h24
`define SAS_IDX_Y_WARN     7'h26
`define SAS_IDX_X_CRIT     7'h28
`define SAS_IDX_Y_CRIT     7'h2a
`define SAS_IDX_SYS_LVL    7'h2e
`define SAS_IDX_CTRL       7'h30
`define SAS_IDX_DIAG       7'h34
`define SAS_IDX_GCMD       7'h36
`define SAS_IDX_X_STAT     7'h38
`define SAS_IDX_Y_STAT     7'h3a
`define SAS_IDX_X_PEAK     7'h3c
`define SAS_IDX_Y_PEAK     7'h3e
`define SAS_IDX_X_BIN      7'h44
`define SAS_IDX_Y_BIN      7'h46
`define SAS_IDX_OUT_CTRL   7'h50

// Page field of the byte address and legal page range
`define SAS_PAGE_LSB       9
`define SAS_PAGE_FIRST     3'h1
`define SAS_PAGE_LAST      3'h6

// Reset values
`define SAS_CTRL_RESET     16'h0080
`define SAS_ZERO16         16'h0000

// Alarm control fields
`define SAS_CTRL_X_EN      0
`define SAS_CTRL_Y_EN      1
`define SAS_CTRL_SYS_EN    3
`define SAS_CTRL_SYS_TEMP  4
`define SAS_CTRL_SYS_BELOW 5
`define SAS_CTRL_DO_EN     6
`define SAS_CTRL_DLY_LSB   8

// Global command bits and output control bits
`define SAS_GCMD_CLEAR     9
`define SAS_GCMD_SAVE      12
`define SAS_OUT_FIRST_SEL  0
`define SAS_OUT_SECOND_SEL 1

// Bus answers
`define SAS_RESP_OKAY      2'h0
`define SAS_RESP_SLVERR    2'h2

`endif

// file: sas_host.sv
// Host bus master model for the bank's register port.
// Assumes the bank answers; the bench cuts hangs short.
`timescale 1ns/100ps
module sas_host (
   input  wire        clk, awr, wrdy, bvl, arr, rv,
   input  wire [31:0] rdat,
   output reg  [11:0] awa = '0, ara = '0,
   output reg  [31:0] wd = '0,
   output reg         awv = 0, wv = 0, brd = 0, arv = 0, rr = 0
);
   task wr(input [11:0] a, input [31:0] d);
      @(posedge clk);
      awa <= a;
      wd <= d;
      {awv, wv, brd} <= 3'b111;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
      end while (!bvl);
      brd <= 1'b0;
   endtask
   task rd(input [11:0] a, output [31:0] d);
      @(posedge clk);
      ara <= a;
      {arv, rr} <= 2'b11;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      d = rdat;
      rr <= 1'b0;
   endtask
endmodule

// file: sas_regs_chk.sv
// Port checks for the alarm register bank.
// Assumes one clock with synchronous active-high reset.
`timescale 1ns/100ps
module sas_regs_chk (
   input wire        clk, srst, rec_end, hdr_valid, nv_clear, nv_save,
   input wire        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
   input wire        s_axi_rvalid, s_axi_rready,
   input wire [2:0]  rec_node, nv_node,
   input wire [15:0] hdr_x_stat
);
   reg [7:0] saved;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Save stays locked per node until a clear
   always @(posedge clk) begin
      if (srst) saved <= 8'h00;
      else if (nv_clear) saved[nv_node] <= 1'b0;
      else if (nv_save) saved[nv_node] <= 1'b1;
   end
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_b_hold: assert property (p_b_hold) else $error("bvalid lost");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
   a_r_hold: assert property (p_r_hold) else $error("rvalid lost");
   property p_r_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_r_ans: assert property (p_r_ans) else $error("rvalid late");
   property p_ar_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_busy: assert property (p_ar_busy) else $error("arready while busy");
   property p_hdr; rec_end && rec_node > 3'h0 && rec_node < 3'h7 |=> hdr_valid; endproperty
   a_hdr: assert property (p_hdr) else $error("no header");
   property p_stat; hdr_valid |-> !hdr_x_stat[3] && hdr_x_stat[2:0] < 3'h7; endproperty
   a_stat: assert property (p_stat) else $error("bad band field");
   property p_clr; nv_clear |=> !nv_clear && !nv_save; endproperty
   a_clr: assert property (p_clr) else $error("clear too long");
   property p_save; nv_save |-> !saved[nv_node]; endproperty
   a_save: assert property (p_save) else $error("save not ignored");
   c_hdr: cover property (hdr_valid);
   c_save: cover property (nv_save);
   c_clr: cover property (nv_clear);
endmodule
bind sas_regs sas_regs_chk i_chk (.*);

// file: sas_regs_test.sv
// Self-checking bench for the alarm register bank.
// Assumes the host model and checker compile alongside.
`timescale 1ns/100ps
module sas_regs_test;
   reg         clk = 0, srst = 1, rs = 0, re = 0, bv = 0;
   reg  [2:0]  node = 1, band = 0;
   reg  [7:0]  idx = 0;
   reg  [15:0] mag = 0, lfsr = 16'h0cc7, lvl;
   reg  [31:0] d, v, n_fail = 0, compares = 0, nsv = 0, ncl = 0, cyc = 0;
   reg  [6:0]  ix [0:9];
   wire [11:0] awa, ara;
   wire [31:0] wd, rdat;
   wire        awv, awr, wv, wrdy, bvl, brd, arv, arr, rv, rr, nvc, nvs;
   wire [5:0]  do1, do2;
   integer     p, b, i;
   reg  [1:0]  rate = 0;
   reg  [15:0] tmp = 0;
   wire [15:0] hx, hp, hd;
   wire [7:0]  hb;
   wire [2:0]  hn;
   wire [1:0]  brs, rrs;
   sas_host i_host (.clk, .awa, .ara, .wd, .rdat, .awv, .awr, .wv, .wrdy, .bvl, .brd, .arv,
      .arr, .rv, .rr);
   sas_regs i_dut (.clk, .srst, .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
      .s_axi_bresp(brs), .s_axi_bvalid(bvl), .s_axi_bready(brd), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rrs),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .rec_start(rs), .rec_end(re), .rec_node(node),
      .rec_rate(rate), .rec_temp(tmp), .rec_supply(16'h0000), .bin_valid(bv),
      .bin_index(idx), .bin_band(band), .bin_x_mag(mag), .bin_y_mag(16'h0000),
      .hdr_valid(), .hdr_node(hn), .hdr_diag(hd), .hdr_x_stat(hx), .hdr_y_stat(),
      .hdr_x_peak(hp), .hdr_y_peak(), .hdr_x_bin(hb), .hdr_y_bin(), .nv_clear(nvc),
      .nv_save(nvs),
      .nv_node(), .digital_out_first(do1), .digital_out_second(do2));
   function [15:0] nxt();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction
   function [11:0] adr(input [6:0] x); return {p[2:0], x, 2'b00}; endfunction
   function [31:0] stat(input integer n); return (32'h0000_0003 << (2 * n + 2)) | n; endfunction
   task chk(input [31:0] g, e);
      compares = compares + 1;
      if (g !== e) begin
         n_fail = n_fail + 1;
         $display("ERROR %0t got %h want %h", $time, g, e);
      end
   endtask
   task finish_test;
      if (n_fail == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // One record of a single bin in the chosen band
   task rec_run(input [15:0] m);
      rs <= 1'b1;
      @(posedge clk);
      rs <= 1'b0;
      bv <= 1'b1;
      mag <= m;
      @(posedge clk);
      bv <= 1'b0;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      nsv <= nsv + nvs;
      ncl <= ncl + nvc;
      if (cyc == 4000) begin
         n_fail = n_fail + 1;
         finish_test;
      end
   end
   initial begin
      ix = '{7'h28, 7'h2a, 7'h2e, 7'h38, 7'h3a, 7'h3c, 7'h3e, 7'h44, 7'h46, 7'h60};
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      p = 1 + nxt() % 6;
      for (i = 0; i < 10; i++) begin
         i_host.rd(adr(ix[i]), d);
         chk(d, 0);
         v = nxt();
         i_host.wr(adr(ix[i]), v);
         i_host.rd(adr(ix[i]), d);
         chk(d, i < 3 ? v : 0);
      end
      i_host.wr(12'hea0, v);
      chk(brs, 2);
      i_host.rd(12'hea0, d);
      chk(rrs, 2);
      chk(d, 0);
      for (i = 0; i < 4; i++) begin
         i_host.wr(adr(7'h36), i == 2 ? 32'h0000_0200 : 32'h0000_1000);
         repeat (3) @(posedge clk);
         chk(nsv, i < 2 ? 1 : i - 1);
      end
      chk(ncl, 1);
      i_host.rd(adr(7'h28), d);
      chk(d, 0);
      lvl = (nxt() >> 1) | 16'h0001;
      b = 1 + nxt() % 6;
      i_host.wr(adr(7'h28), lvl);
      i_host.wr(adr(7'h50), 3);
      i_host.wr(adr(7'h2e), 32'h0000_1000);
      i_host.wr(adr(7'h30), 32'h0000_0159);
      node <= p[2:0];
      tmp <= 16'h2000;
      band <= b[2:0];
      idx <= lvl[8:1];
      // Delay of one record: flags only on the second; a rate change restarts the count
      for (i = 0; i < 3; i++) begin
         rate <= {1'b0, i == 2};
         rec_run(lvl + 16'h0001);
         i_host.rd(adr(7'h38), d);
         chk(d, i == 1 ? stat(b) : b);
         chk(do1[p - 1], i == 1);
         chk(do2[p - 1], i == 1);
      end
      i_host.rd(adr(7'h3c), d);
      chk(d, lvl + 1);
      i_host.rd(adr(7'h44), d);
      chk(d, idx);
      chk(hn, p);
      chk(hx, b);
      chk(hp, lvl + 1);
      chk(hb, idx);
      chk(hd, 16'h0001);
      finish_test;
   end
endmodule
